// File: hw/dram_access_ready_timing_regs.vh
// Constants for the DRAM access, refresh and ready sequencer
// Notes on behaviour
// [R1] Column strobe falls only after both latch-strobe and access-strobe delays have elapsed, except on a grant cycle, timed per R5 without them.
// [R2] Ready rises only on a system clock rising edge, except the wait-state case.
// [R3] Zero wait: on an access-grant cycle, ready rises with the row strobe.
// [R4] One wait: ready rises one system clock rise after access strobe or row strobe.
// [R5] Grant cycle: early access strobe times column from rise, late from next fall.
// [R6] Wait states: strobe low while clock high times ready from the strobe itself.
// [R7] Refresh versus access arbitration happens on a system clock falling edge.
// [R8] Latch strobe high with refresh pending: refresh address out, refresh begins.
// [R9] Ready drops after latch strobe falls when wait states or a refresh apply.
// [R10] Wait-state select is a static strap, sampled continuously.
`ifndef DRAM_ACCESS_READY_TIMING_REGS_VH
`define DRAM_ACCESS_READY_TIMING_REGS_VH
`define CLK_MHZ        125
`define ALE_CAS_NS     60
`define ACC_CAS_NS     40
`define ALE_CAS_CYC    ((`ALE_CAS_NS * `CLK_MHZ + 999) / 1000)
`define ACC_CAS_CYC    ((`ACC_CAS_NS * `CLK_MHZ + 999) / 1000)
`define LATE_ACC_NS    20
`define LATE_ACC_CYC   ((`LATE_ACC_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_STAGES    3
`define PIN_SYSCLK     0
`define PIN_ALE        1
`define PIN_ACC_N      2
`define PIN_REF_N      3
`define PIN_WAIT       4
`define PIN_COUNT      5
`define PIN_IDLE_LEVELS 5'h0c
`define REFRESH_RESET  8'h00
`endif

// File: hw/dram_access_ready_timing.v
// Access, refresh and ready sequencer of a DRAM controller
`timescale 1ns/1ps
`include "dram_access_ready_timing_regs.vh"
module dram_access_ready_timing #(
  parameter ADDR_W = 8
) (
  input  wire              clk_in,
  input  wire              rst_in,
  input  wire              sys_clk_in,
  input  wire              ale_in,
  input  wire              access_strobe_n_in,
  input  wire              refresh_request_n_in,
  input  wire              wait_state_select_in,
  input  wire [ADDR_W-1:0] row_addr_in,
  input  wire [ADDR_W-1:0] col_addr_in,
  output reg  [ADDR_W-1:0] memory_address_out,
  output reg               ras_n_out,
  output reg               cas_n_out,
  output reg               ready_out,
  output reg               refresh_active_out
);

  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_ACC   = 5'h02;
  localparam [4:0] ST_REF   = 5'h04;
  localparam [4:0] ST_RFRAS = 5'h08;
  localparam [4:0] ST_GRANT = 5'h10;
  localparam integer ALE_CYC_I  = `ALE_CAS_CYC;
  localparam integer ACC_CYC_I  = `ACC_CAS_CYC;
  localparam integer LATE_CYC_I = `LATE_ACC_CYC;
  localparam [7:0] ALE_CYC  = ALE_CYC_I[7:0];
  localparam [7:0] ACC_CYC  = ACC_CYC_I[7:0];
  localparam [7:0] LATE_CYC = LATE_CYC_I[7:0];
  // Idle level of each pin; the active-low strobes rest high
  localparam [`PIN_COUNT-1:0] PIN_IDLE = `PIN_IDLE_LEVELS;

  reg [`SYNC_STAGES-1:0] sync [0:`PIN_COUNT-1];
  reg [`PIN_COUNT-1:0]   pin;
  reg [`PIN_COUNT-1:0]   pin_d;
  wire [`PIN_COUNT-1:0]  raw;
  assign raw = {wait_state_select_in, refresh_request_n_in, access_strobe_n_in,
                ale_in, sys_clk_in};

  // Three-stage synchronisers; a change is accepted once stages two and three agree.
  // Reset loads each pin's idle level, else a false request or edge follows reset.
  genvar g;
  generate
    for (g = 0; g < `PIN_COUNT; g = g + 1) begin : g_sync
      always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
          sync[g]  <= {`SYNC_STAGES{PIN_IDLE[g]}};
          pin[g]   <= PIN_IDLE[g];
          pin_d[g] <= PIN_IDLE[g];
        end else begin
          sync[g]  <= {sync[g][`SYNC_STAGES-2:0], raw[g]};
          if (sync[g][1] == sync[g][2])
            pin[g] <= sync[g][2];
          pin_d[g] <= pin[g];
        end
      end
    end
  endgenerate

  // Edge events on the filtered pins
  wire sclk_rise = pin[`PIN_SYSCLK] & ~pin_d[`PIN_SYSCLK];
  wire sclk_fall = ~pin[`PIN_SYSCLK] & pin_d[`PIN_SYSCLK];
  wire ale_fall  = ~pin[`PIN_ALE] & pin_d[`PIN_ALE];
  wire acc_fall  = ~pin[`PIN_ACC_N] & pin_d[`PIN_ACC_N];
  wire acc_rise  = pin[`PIN_ACC_N] & ~pin_d[`PIN_ACC_N];
  wire acc_low   = ~pin[`PIN_ACC_N];
  wire ref_req   = ~pin[`PIN_REF_N];
  wire wait_sel  = pin[`PIN_WAIT]; // Strap read live, no latch at reset [R10]

  reg [4:0]        state;
  reg [ADDR_W-1:0] row_q;
  reg [ADDR_W-1:0] col_q;
  reg [ADDR_W-1:0] refresh_addr;
  reg              access_pend;
  reg              ref_pend;
  reg [7:0]        ale_cnt;
  reg [7:0]        acc_cnt;
  reg              ale_done;
  reg              acc_done;
  reg              acc_seen;
  reg              acc_early;
  reg              cas_armed;
  reg              cas_wait_fall;
  reg              ready_pend;

  // Delay counters for the column strobe, restarted by each strobe's falling edge
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ale_cnt  <= 8'h00;
      acc_cnt  <= 8'h00;
      ale_done <= 1'b0;
      acc_done <= 1'b0;
      acc_seen <= 1'b0;
    end else begin
      if (ale_fall) begin
        ale_cnt  <= 8'h01;
        ale_done <= 1'b0;
      end else if (!ale_done && ale_cnt != 8'h00) begin
        ale_cnt  <= ale_cnt + 8'h01;
        ale_done <= (ale_cnt >= ALE_CYC - 8'h01);
      end
      if (acc_fall) begin
        acc_cnt  <= 8'h01;
        acc_done <= 1'b0;
        acc_seen <= 1'b1;
      end else if (acc_rise) begin
        acc_cnt  <= 8'h00;
        acc_done <= 1'b0;
        acc_seen <= 1'b0;
      end else if (!acc_done && acc_cnt != 8'h00) begin
        acc_cnt  <= acc_cnt + 8'h01;
        acc_done <= (acc_cnt >= ACC_CYC - 8'h01);
      end
    end
  end

  // Main sequencer; the pending refresh request is held until served
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state              <= ST_IDLE;
      row_q              <= {ADDR_W{1'b0}};
      col_q              <= {ADDR_W{1'b0}};
      refresh_addr       <= `REFRESH_RESET;
      access_pend        <= 1'b0;
      ref_pend           <= 1'b0;
      acc_early          <= 1'b0;
      cas_armed          <= 1'b0;
      cas_wait_fall      <= 1'b0;
      ready_pend         <= 1'b0;
      memory_address_out <= {ADDR_W{1'b0}};
      ras_n_out          <= 1'b1;
      cas_n_out          <= 1'b1;
      ready_out          <= 1'b1;
      refresh_active_out <= 1'b0;
    end else begin
      if (ref_req)
        ref_pend <= 1'b1;
      // Latch strobe falling opens an access; ready drops if wait states are selected or a refresh is running
      if (ale_fall) begin
        row_q       <= row_addr_in;
        col_q       <= col_addr_in;
        access_pend <= 1'b1;
        acc_early   <= acc_low | acc_fall;
        if (wait_sel || state == ST_REF || state == ST_RFRAS)
          ready_out <= 1'b0; // [R9]
      end else if (acc_fall && access_pend && ale_cnt < LATE_CYC && ale_cnt != 8'h00) begin
        acc_early <= 1'b1; // Within the skew window the strobes count as coincident
      end
      // One wait state on a plain access; the strobe may fall before the row strobe,
      // so this also runs in idle, and the falling edge itself counts [R6]
      if (wait_sel && !ready_out && access_pend && (acc_seen || acc_fall) &&
          (state == ST_IDLE || state == ST_ACC)) begin
        if (acc_fall && pin[`PIN_SYSCLK])
          ready_out <= 1'b1; // [R6]
        else if (sclk_rise)
          ready_out <= 1'b1; // [R4] [R2]
      end
      case (state)
        ST_IDLE: begin
          if (sclk_fall) begin
            // Refresh wins while the latch strobe is high and the bus is idle [R7]
            if (ref_pend && pin[`PIN_ALE] && !acc_low) begin
              memory_address_out <= refresh_addr; // [R8]
              refresh_active_out <= 1'b1;
              state              <= ST_REF;
            end else if (access_pend) begin
              memory_address_out <= row_q; // [R7]
              ras_n_out          <= 1'b0;
              state              <= ST_ACC;
            end
          end
        end
        ST_ACC: begin
          // Column strobe needs both delays; a late access strobe dominates [R1]
          if (ale_done && acc_done && acc_low && cas_n_out) begin
            memory_address_out <= col_q;
            cas_n_out          <= 1'b0;
          end
          if (acc_rise) begin
            ras_n_out   <= 1'b1;
            cas_n_out   <= 1'b1;
            access_pend <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        ST_REF: begin
          if (sclk_rise) begin
            ras_n_out <= 1'b0;
            state     <= ST_RFRAS;
          end
        end
        ST_RFRAS: begin
          // Refresh row strobe spans one system clock period
          if (sclk_rise) begin
            refresh_addr       <= refresh_addr + {{(ADDR_W-1){1'b0}}, 1'b1};
            ref_pend           <= ref_req;
            refresh_active_out <= 1'b0;
            if (access_pend) begin
              // Grant cycle: row strobe restarts on this same rising edge
              memory_address_out <= row_q;
              ras_n_out          <= 1'b0;
              cas_armed          <= acc_early;
              cas_wait_fall      <= ~acc_early;
              ready_out          <= ~wait_sel; // [R3] [R2]
              ready_pend         <= wait_sel;
              state              <= ST_GRANT;
            end else begin
              ras_n_out <= 1'b1;
              ready_out <= 1'b1; // [R2]
              state     <= ST_IDLE;
            end
          end
        end
        ST_GRANT: begin
          // Early strobe: column from the rise; late strobe: from next fall [R5]
          if (cas_wait_fall && sclk_fall) begin
            cas_wait_fall <= 1'b0;
            cas_armed     <= 1'b1; // [R5]
          end
          if (cas_armed && acc_low && cas_n_out) begin
            memory_address_out <= col_q; // [R5]
            cas_n_out          <= 1'b0;
            cas_armed          <= 1'b0;
          end
          // Rise after the one that lowered the row strobe [R4]
          if (ready_pend && sclk_rise && acc_low) begin
            ready_out  <= 1'b1; // [R4] [R2]
            ready_pend <= 1'b0;
          end
          if (acc_rise) begin
            ras_n_out     <= 1'b1;
            cas_n_out     <= 1'b1;
            access_pend   <= 1'b0;
            cas_armed     <= 1'b0;
            cas_wait_fall <= 1'b0;
            ready_pend    <= 1'b0;
            ready_out     <= 1'b1;
            state         <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: testbench/dram_access_ready_timing_sva.sv
// Port-level checks of the DRAM access, refresh and ready sequencer
`timescale 1ns/1ps
module dram_access_ready_timing_sva #(
  parameter ADDR_W = 8
) (
  input wire clk_in,
  input wire rst_in,
  input wire sys_clk_in,
  input wire ale_in,
  input wire access_strobe_n_in,
  input wire wait_state_select_in,
  input wire ras_n_out,
  input wire cas_n_out,
  input wire ready_out,
  input wire refresh_active_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Pin events reach the logic about four cycles late, so the look-backs are short
  chk_cas_ale_delay: assert property ($fell(cas_n_out) |-> $past(ale_in, 8) == 1'b0)
    else $error("column strobe before latch delay");
  chk_cas_acc_delay: assert property ($fell(cas_n_out) |-> $past(access_strobe_n_in, 5) == 1'b0)
    else $error("column strobe before access delay");
  chk_cas_under_ras: assert property (!cas_n_out |-> !ras_n_out)
    else $error("column strobe without row strobe");
  chk_ras_sys_fall: assert property ($fell(ras_n_out) && !refresh_active_out |-> $past(sys_clk_in, 3) == 1'b0)
    else $error("access row strobe not after clock fall");
  chk_ready_drop: assert property ($fell(ale_in) && wait_state_select_in |-> ##[2:7] !ready_out)
    else $error("ready not dropped after latch");
  chk_ready_rise_cause: assert property ($rose(ready_out) && !$fell(refresh_active_out) |-> $past(access_strobe_n_in, 3) == 1'b0)
    else $error("ready rose without access strobe");
  chk_zero_wait_grant: assert property ($fell(refresh_active_out) && !wait_state_select_in |-> ready_out)
    else $error("ready late on grant cycle");
  chk_wait_ready_bound: assert property ($fell(access_strobe_n_in) && wait_state_select_in && !refresh_active_out |-> ##[3:24] ready_out)
    else $error("ready not raised after access strobe");
  chk_refresh_ras: assert property ($rose(refresh_active_out) |-> ras_n_out ##[1:14] !ras_n_out)
    else $error("refresh row strobe missing");
  cover property ($fell(cas_n_out));
  cover property ($fell(refresh_active_out) && !ras_n_out);
  cover property ($rose(ready_out) && wait_state_select_in);
endmodule
bind dram_access_ready_timing dram_access_ready_timing_sva #(.ADDR_W(ADDR_W)) sva_inst (
  .clk_in(clk_in), .rst_in(rst_in), .sys_clk_in(sys_clk_in), .ale_in(ale_in),
  .access_strobe_n_in(access_strobe_n_in), .wait_state_select_in(wait_state_select_in),
  .ras_n_out(ras_n_out), .cas_n_out(cas_n_out), .ready_out(ready_out),
  .refresh_active_out(refresh_active_out));

// File: testbench/cpu_bus_model.sv
// Processor model: system clock, latch strobe, access strobe and addresses
`timescale 1ns/1ps
module cpu_bus_model (
  input  wire        clk_in,
  output logic       sys_clk_out,
  output logic       ale_out = 1'b0,
  output logic       access_strobe_n_out = 1'b1,
  output logic [7:0] row_out = 8'h00,
  output logic [7:0] col_out = 8'h00
);
  logic [2:0] div = 3'h0;
  // Free-running system clock, eight fast cycles a period
  always @(posedge clk_in) begin
    div <= div + 3'h1;
  end
  assign sys_clk_out = div[2];
  // One access; the strobe falls early in the chosen clock phase so it is unambiguous
  task automatic do_access(input logic [7:0] r, input logic [7:0] c, input logic phase,
                           input int gap, input int hold);
    @(posedge clk_in);
    ale_out <= 1'b1;
    row_out <= r;
    col_out <= c;
    repeat (hold) @(posedge clk_in);
    ale_out <= 1'b0;
    repeat (gap) @(posedge clk_in);
    while (div !== {phase, 2'b00}) @(posedge clk_in);
    access_strobe_n_out <= 1'b0;
    repeat (40) @(posedge clk_in);
    access_strobe_n_out <= 1'b1;
    row_out <= ~r; // Released bus shows a changed pattern, never stale values
    col_out <= ~c;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// File: testbench/dram_access_ready_timing_tb.sv
// Self-checking bench for the DRAM access, refresh and ready sequencer
`timescale 1ns/1ps
module dram_access_ready_timing_tb;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic       refresh_request_n = 1'b1;
  logic       wait_sel = 1'b0;
  logic       sys_clk, ale, acc_n, ras_n, cas_n, ready, ref_act, rdy_low;
  logic       ras_q = 1'b1;
  logic       cas_q = 1'b1;
  logic       ref_q = 1'b0;
  logic       acc_q = 1'b1;
  logic       rdy_q = 1'b1;
  int         ref_end = 0;
  int         cas_at = 0;
  int         rdy_at = 0;
  int         acc_at = 0;
  logic [7:0] row, col, mem_addr, ras_addr, cas_addr, ref_addr;
  int         mismatches = 0;
  int         check_count = 0;
  int         cycles = 0;
  always #4 clk_in = ~clk_in;
  cpu_bus_model cpu_bus_model_inst (.clk_in(clk_in), .sys_clk_out(sys_clk), .ale_out(ale),
    .access_strobe_n_out(acc_n), .row_out(row), .col_out(col));
  dram_access_ready_timing dram_access_ready_timing_inst (.clk_in(clk_in), .rst_in(rst_in),
    .sys_clk_in(sys_clk), .ale_in(ale), .access_strobe_n_in(acc_n),
    .refresh_request_n_in(refresh_request_n), .wait_state_select_in(wait_sel),
    .row_addr_in(row), .col_addr_in(col), .memory_address_out(mem_addr), .ras_n_out(ras_n),
    .cas_n_out(cas_n), .ready_out(ready), .refresh_active_out(ref_act));
  // Capture addresses at strobe falls; drop the refresh request once it is taken
  always @(posedge clk_in) begin
    ras_q <= ras_n;
    cas_q <= cas_n;
    ref_q <= ref_act;
    acc_q <= acc_n;
    rdy_q <= ready;
    cycles <= cycles + 1;
    if (cas_q && !cas_n) cas_at <= cycles;
    if (ref_q && !ref_act) ref_end <= cycles;
    if (!rdy_q && ready) rdy_at <= cycles;
    if (acc_q && !acc_n) acc_at <= cycles;
    if (ras_q && !ras_n) ras_addr <= mem_addr;
    if (cas_q && !cas_n) cas_addr <= mem_addr;
    if (!ready) rdy_low <= 1'b1;
    if (!ref_q && ref_act) begin
      ref_addr <= mem_addr;
      refresh_request_n <= 1'b1;
    end
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Plain access; the strap only changes while idle
  task automatic test_access(input logic ws, input logic phase, input int gap);
    @(posedge clk_in);
    wait_sel <= ws;
    rdy_low <= 1'b0;
    cas_addr <= 8'h00;
    ras_addr <= 8'h00;
    repeat (4) @(posedge clk_in);
    cpu_bus_model_inst.do_access(8'h5a, 8'ha5, phase, gap, 3);
    // Strobe in the high phase: pin latency only; low phase: next clock rise, 3 later
    if (ws) check("ready after access strobe", 8'(rdy_at - acc_at), phase ? 8'h05 : 8'h08);
    check("row at row strobe", ras_addr, 8'h5a);
    check("column at column strobe", cas_addr, 8'ha5);
    check("ready dropped", {7'h00, rdy_low}, {7'h00, ws});
    check("ready at end", {7'h00, ready}, 8'h01);
    $display("test_access done wait=%0d phase=%0d gap=%0d", ws, phase, gap);
  endtask
  // Refresh taken while the latch strobe is high; the latch strobe falls inside the
  // refresh, so the access is granted. Phase 0 drops the access strobe one cycle after
  // the latch strobe (coincident), phase 1 some 40 ns after it (late).
  task automatic test_grant(input logic ws, input logic phase, input logic [7:0] count);
    @(posedge clk_in);
    wait_sel <= ws;
    cas_addr <= 8'h00;
    ref_addr <= 8'hff;
    refresh_request_n <= 1'b0;
    repeat (4) @(posedge clk_in);
    // Raise the latch strobe one cycle before a system clock fall
    while (cpu_bus_model_inst.div !== 3'h5) @(posedge clk_in);
    cpu_bus_model_inst.do_access(8'h96, 8'h69, phase, 0, 9);
    check("refresh row address", ref_addr, count);
    check("column after grant", cas_addr, 8'h69);
    // Early: right after the row strobe edge; late: after the next clock fall, 4 later
    check("column delay after grant", 8'(cas_at - ref_end), phase ? 8'h05 : 8'h01);
    // Zero wait: with the row strobe; one wait: one system clock period later
    check("ready delay after grant", 8'(rdy_at - ref_end), ws ? 8'h08 : 8'h00);
    check("ready after grant", {7'h00, ready}, 8'h01);
    $display("test_grant done wait=%0d phase=%0d", ws, phase);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    test_access(1'b0, 1'b1, 0);
    test_access(1'b0, 1'b0, 10);
    test_access(1'b1, 1'b1, 0);
    test_access(1'b1, 1'b0, 0);
    test_grant(1'b0, 1'b1, 8'h00);
    test_grant(1'b0, 1'b0, 8'h01);
    test_grant(1'b1, 1'b1, 8'h02);
    test_grant(1'b1, 1'b0, 8'h03);
    summarize();
  end
endmodule
